/* File: design/arx_receiver.sv */
// arx_receiver: asynchronous serial receive front end with multidrop filter and APB registers.
// assumes: APB master per AMBA; rxd idles high; transmitter lives outside and reads the size outputs.
`timescale 1ns/1ps
`default_nettype none
module arx_receiver
  import arx_pkg::*;
#(
  parameter int DIV_W = 12,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic tx_frame_done,
  output logic [2:0] char_size_select,
  output logic stop_bits_select,
  output logic double_rate_select,
  output logic [DIV_W-1:0] baud_divider
);

  //////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  function automatic logic [4:0] samples_per_bit(input logic dbl);
    samples_per_bit = dbl ? ARX_SPB_DOUBLE : ARX_SPB_NORMAL;
  endfunction : samples_per_bit

  function automatic logic [4:0] first_vote(input logic dbl);
    first_vote = dbl ? ARX_FIRST_DOUBLE : ARX_FIRST_NORMAL;
  endfunction : first_vote

  // number of data bits; reserved codes fall back to eight
  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    if (csz == ARX_CSZ_NINE) begin
      data_bits = 4'h9;
    end else if (csz[2]) begin
      data_bits = 4'h8;
    end else begin
      data_bits = 4'h5 + {2'h0, csz[1:0]};
    end
  endfunction : data_bits

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    is_addr = (a == ADDR_W'(off));
  endfunction : is_addr

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    arx_rx_state_t state;
    logic [4:0] cnt;
    logic [3:0] bit_idx;
    logic samp_a;
    logic samp_b;
    logic last_level;
    logic [8:0] shift;
    logic filt_en;
    logic dbl;
    logic tx_done;
    logic rx_en;
    logic [2:0] csz;
    logic sbs;
    logic [DIV_W-1:0] div;
    logic [8:0] hold_data;
    logic hold_fault;
    logic pending;
    logic overrun;
    logic [31:0] prdata;
  } arx_rx_st_t;

  arx_rx_st_t q;
  arx_rx_st_t d;

  logic rxd_sync;
  logic tick;

  arx_sample_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .divider(q.div),
    .rxd(rxd),
    .rxd_sync(rxd_sync),
    .tick(tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic setup_phase;
  logic access_phase;
  logic mapped;
  logic wr_a;
  logic wr_b;
  logic wr_div;
  logic pop;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign mapped = is_addr(paddr, ARX_OFF_CTRL_STAT_A) | is_addr(paddr, ARX_OFF_CTRL_B)
                | is_addr(paddr, ARX_OFF_DATA_WINDOW) | is_addr(paddr, ARX_OFF_BAUD_DIVIDER);
  assign wr_a = access_phase & pwrite & is_addr(paddr, ARX_OFF_CTRL_STAT_A);
  assign wr_b = access_phase & pwrite & is_addr(paddr, ARX_OFF_CTRL_B);
  assign wr_div = access_phase & pwrite & is_addr(paddr, ARX_OFF_BAUD_DIVIDER);
  // reading the data window takes the held frame
  assign pop = access_phase & ~pwrite & is_addr(paddr, ARX_OFF_DATA_WINDOW);

  function automatic logic [31:0] read_mux(input arx_rx_st_t s, input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (is_addr(a, ARX_OFF_CTRL_STAT_A)) begin
      v[ARX_A_PENDING_BIT] = s.pending;
      v[ARX_A_TXDONE_BIT] = s.tx_done;
      v[ARX_A_FAULT_BIT] = s.hold_fault;
      v[ARX_A_OVERRUN_BIT] = s.overrun;
      v[ARX_A_DOUBLE_BIT] = s.dbl;
      v[ARX_A_FILTER_BIT] = s.filt_en;
    end else if (is_addr(a, ARX_OFF_CTRL_B)) begin
      v[ARX_B_RXEN_BIT] = s.rx_en;
      v[ARX_B_CSZ_LSB +: 3] = s.csz;
      v[ARX_B_SBS_BIT] = s.sbs;
    end else if (is_addr(a, ARX_OFF_DATA_WINDOW)) begin
      v[8:0] = s.hold_data;
    end else if (is_addr(a, ARX_OFF_BAUD_DIVIDER)) begin
      v[DIV_W-1:0] = s.div;
    end
    read_mux = v;
  endfunction : read_mux

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic [4:0] spb;
  logic [4:0] first;
  logic [4:0] last;
  logic [3:0] nbits;
  logic vote;
  logic frame_type;
  logic accept;

  assign spb = samples_per_bit(q.dbl);
  assign first = first_vote(q.dbl);
  assign last = first + 5'h02;
  assign nbits = data_bits(q.csz);
  assign vote = maj3(q.samp_a, q.samp_b, rxd_sync);
  // type bit: ninth data bit or first stop bit
  assign frame_type = (q.csz == ARX_CSZ_NINE) ? q.shift[8] : vote;
  // with filter on only address frames pass
  assign accept = ~q.filt_en | frame_type;

  always_comb begin
    d = q;

    // register writes
    if (wr_a) begin
      // software sets and clears the filter enable directly
      d.filt_en = pwdata[ARX_A_FILTER_BIT];
      d.dbl = pwdata[ARX_A_DOUBLE_BIT];
    end
    // transmit-done shares the word; writing one clears it, a new event wins
    if (wr_a && pwdata[ARX_A_TXDONE_BIT]) begin
      d.tx_done = 1'b0;
    end
    if (tx_frame_done) begin
      d.tx_done = 1'b1;
    end
    if (wr_b) begin
      d.rx_en = pwdata[ARX_B_RXEN_BIT];
      d.csz = pwdata[ARX_B_CSZ_LSB +: 3];
      d.sbs = pwdata[ARX_B_SBS_BIT];
    end
    if (wr_div) begin
      d.div = pwdata[DIV_W-1:0];
    end
    if (pop) begin
      d.pending = 1'b0;
    end

    // read data captured in the setup cycle
    if (setup_phase) begin
      d.prdata = read_mux(q, paddr);
    end

    // receive sequencer
    if (!q.rx_en) begin
      d.state = ARX_IDLE;
      d.pending = 1'b0;
      d.overrun = 1'b0;
      d.last_level = 1'b1;
    end else if (tick) begin
      case (q.state)
        ARX_IDLE: begin
          d.last_level = rxd_sync;
          // falling edge seen: this is sample one
          if (q.last_level && !rxd_sync) begin
            d.state = ARX_START;
            d.cnt = 5'h01;
            d.shift = 9'h000;
          end
        end
        ARX_START: begin
          if (q.cnt == first) begin
            d.samp_a = rxd_sync;
          end
          if (q.cnt == first + 5'h01) begin
            d.samp_b = rxd_sync;
          end
          // majority high rejects the start as noise
          if (q.cnt == last && vote) begin
            d.state = ARX_IDLE;
            d.last_level = rxd_sync;
          end else if (q.cnt == spb) begin
            // bit phase now locked to this start bit
            d.state = ARX_BITS;
            d.cnt = 5'h01;
            d.bit_idx = 4'h0;
          end else begin
            d.cnt = q.cnt + 5'h01;
          end
        end
        ARX_BITS: begin
          if (q.cnt == first) begin
            d.samp_a = rxd_sync;
          end
          if (q.cnt == first + 5'h01) begin
            d.samp_b = rxd_sync;
          end
          if (q.cnt == last && q.bit_idx == nbits) begin
            // frame ends at the first stop bit
            // return to edge search right after the last vote
            d.state = ARX_IDLE;
            d.last_level = rxd_sync;
            if (accept) begin
              if (q.pending && !pop) begin
                d.overrun = 1'b1;
              end else begin
                d.hold_data = {(q.csz == ARX_CSZ_NINE) & q.shift[8], q.shift[7:0]};
                // zero stop bit flags a fault
                d.hold_fault = ~vote;
                // accepted frame raises pending, winning over a same-cycle read
                d.pending = 1'b1;
                d.overrun = 1'b0;
              end
            end
          end else begin
            if (q.cnt == last) begin
              d.shift[q.bit_idx] = vote;
            end
            // one state per sample, wrapping each bit
            if (q.cnt == spb) begin
              d.cnt = 5'h01;
              d.bit_idx = q.bit_idx + 4'h1;
            end else begin
              d.cnt = q.cnt + 5'h01;
            end
          end
        end
        default: begin
          d.state = ARX_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '{
        state: ARX_IDLE,
        cnt: 5'h00,
        bit_idx: 4'h0,
        samp_a: 1'b1,
        samp_b: 1'b1,
        last_level: 1'b1,
        shift: 9'h000,
        filt_en: 1'b0,
        dbl: 1'b0,
        tx_done: 1'b0,
        rx_en: 1'b0,
        csz: ARX_CSZ_RESET,
        sbs: 1'b0,
        div: DIV_W'(ARX_DIV_RESET),
        hold_data: 9'h000,
        hold_fault: 1'b0,
        pending: 1'b0,
        overrun: 1'b0,
        prdata: 32'h0000_0000
      };
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = q.prdata;
  assign pready = access_phase;
  assign pslverr = access_phase & ~mapped;
  // one size setting drives transmitter and receiver
  assign char_size_select = q.csz;
  assign stop_bits_select = q.sbs;
  // filter enable is not exported to the transmitter
  assign double_rate_select = q.dbl;
  assign baud_divider = q.div;

endmodule : arx_receiver
`default_nettype wire

/* File: pkg/arx_pkg.sv */
// arx_pkg: constants for the asynchronous receive front end with multidrop filter.
// assumes: registers reached over a 32-bit APB slave, one word per register.
package arx_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ARX_OFF_CTRL_STAT_A = 8'h00;
  localparam logic [7:0] ARX_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] ARX_OFF_DATA_WINDOW = 8'h08;
  localparam logic [7:0] ARX_OFF_BAUD_DIVIDER = 8'h0C;

  //////////////////////////////////////////////////////////////////////////////
  // control_status_a field positions
  localparam int ARX_A_FILTER_BIT = 0;
  localparam int ARX_A_DOUBLE_BIT = 1;
  localparam int ARX_A_OVERRUN_BIT = 3;
  localparam int ARX_A_FAULT_BIT = 4;
  localparam int ARX_A_TXDONE_BIT = 6;
  localparam int ARX_A_PENDING_BIT = 7;

  // control_b field positions
  localparam int ARX_B_RXEN_BIT = 0;
  localparam int ARX_B_CSZ_LSB = 1;
  localparam int ARX_B_SBS_BIT = 4;

  //////////////////////////////////////////////////////////////////////////////
  // reset values and the nine-bit size code
  localparam logic [2:0] ARX_CSZ_RESET = 3'h3;
  localparam logic [2:0] ARX_CSZ_NINE = 3'h7;
  localparam logic [11:0] ARX_DIV_RESET = 12'h000;

  //////////////////////////////////////////////////////////////////////////////
  // sampling figures: states per bit and first voting sample
  localparam logic [4:0] ARX_SPB_NORMAL = 5'h10;
  localparam logic [4:0] ARX_SPB_DOUBLE = 5'h08;
  localparam logic [4:0] ARX_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] ARX_FIRST_DOUBLE = 5'h04;

  typedef enum logic [1:0] {
    ARX_IDLE,
    ARX_START,
    ARX_BITS
  } arx_rx_state_t;

endpackage : arx_pkg

/* File: design/arx_sample_tick.sv */
// arx_sample_tick: line synchroniser and sample-rate enable divider.
// assumes: rxd is asynchronous; divider value is stable while receiving.
`timescale 1ns/1ps
`default_nettype none
module arx_sample_tick
  import arx_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [DIV_W-1:0] divider,
  input wire logic rxd,
  output logic rxd_sync,
  output logic tick
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic tick;
    logic [DIV_W-1:0] cnt;
  } arx_tick_st_t;

  arx_tick_st_t q;
  arx_tick_st_t d;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.meta = rxd;
    d.sync = q.meta;
    d.tick = 1'b0;
    if (q.cnt == '0) begin
      d.cnt = divider;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - DIV_W'(1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '{meta: 1'b1, sync: 1'b1, tick: 1'b0, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign rxd_sync = q.sync;
  assign tick = q.tick;

endmodule : arx_sample_tick
`default_nettype wire

/* File: sim/arx_receiver_checker.sv */
// arx_receiver_checker: port-level assertions for the receive front end.
// assumes: bound into arx_receiver, sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module arx_receiver_checker
  import arx_pkg::*;
#(
  parameter int DIV_W = 12,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic tx_frame_done,
  input wire logic [2:0] char_size_select,
  input wire logic stop_bits_select,
  input wire logic double_rate_select,
  input wire logic [DIV_W-1:0] baud_divider
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic acc, wr_a, wr_b, wr_d, mapped;
  assign acc = psel && penable;
  assign wr_a = acc && pwrite && paddr == ARX_OFF_CTRL_STAT_A;
  assign wr_b = acc && pwrite && paddr == ARX_OFF_CTRL_B;
  assign wr_d = acc && pwrite && paddr == ARX_OFF_BAUD_DIVIDER;
  assign mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h0C;
  a_ready_access: assert property (pready == acc)
    else $error("pready not tied to access phase");
  a_err_unmapped: assert property (pslverr == (acc && !mapped))
    else $error("pslverr wrong for address");
  a_size_write: assert property (wr_b |=> char_size_select == $past(pwdata[3:1]))
    else $error("size setting not taken");
  a_size_hold: assert property (!wr_b |=> $stable(char_size_select))
    else $error("size setting moved");
  a_stop_write: assert property (wr_b |=> stop_bits_select == $past(pwdata[4]))
    else $error("stop setting not taken");
  a_double_write: assert property (wr_a |=> double_rate_select == $past(pwdata[1]))
    else $error("double rate not taken");
  a_double_hold: assert property (!wr_a |=> $stable(double_rate_select))
    else $error("double rate moved");
  a_div_write: assert property (wr_d |=> baud_divider == $past(pwdata[DIV_W-1:0]))
    else $error("divider not taken");
  a_tx_setting_kept: assert property (wr_a |=> $stable(stop_bits_select) && $stable(baud_divider))
    else $error("filter write moved a transmit setting");
  a_reset_vals: assert property ($fell(rst) |-> char_size_select == ARX_CSZ_RESET && !stop_bits_select
    && !double_rate_select && baud_divider == '0)
    else $error("reset values wrong");
endmodule : arx_receiver_checker
`default_nettype wire

/* File: sim/arx_tx_model.sv */
// arx_tx_model: behavioural remote transmitter driving the serial line.
// assumes: tck clocks per sample tick and spb ticks per bit, set by the bench.
`timescale 1ns/1ps
`default_nettype none
module arx_tx_model (
  input wire logic clock,
  output logic rxd
);
  int spb = 16;
  int tck = 2;
  initial rxd = 1'b1;
  task automatic hold(input logic v, input int t);
    rxd <= v;
    repeat (t * tck) @(posedge clock);
  endtask : hold
  task automatic send(input logic [8:0] d, input int n, input logic s1, input int st);
    hold(1'b0, spb);
    for (int i = 0; i < n; i++) begin
      hold(d[i], spb);
    end
    hold(s1, st);
    if (!s1) begin
      hold(1'b1, spb);
    end
  endtask : send
endmodule : arx_tx_model
`default_nettype wire

/* File: sim/arx_receiver_test.sv */
// arx_receiver_test: self-checking bench for the receive front end.
// assumes: APB master here, remote transmitter model on the line.
`timescale 1ns/1ps
`default_nettype none
module arx_receiver_test
  import arx_pkg::*;
;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, rxd, tx_frame_done, err;
  logic stop_bits_select, double_rate_select;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] char_size_select;
  logic [11:0] baud_divider;
  logic [8:0] d;
  int num_errors = 0, checks = 0, cycles = 0, seed = 34447, n;
  arx_receiver #(.DIV_W(12), .ADDR_W(8)) arx_receiver_inst (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .tx_frame_done, .char_size_select,
    .stop_bits_select, .double_rate_select, .baud_divider);
  arx_tx_model far (.clock, .rxd);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 50000) begin
      num_errors++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic rx_got(input logic [8:0] e, input logic f);
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[7] !== 1'b1 && k < 200) begin
      apb(1'b0, ARX_OFF_CTRL_STAT_A, 32'h0);
      k++;
    end
    chk("pending", 32'h1, {31'h0, rd[7]});
    chk("fault", {31'h0, f}, {31'h0, rd[4]});
    apb(1'b0, ARX_OFF_DATA_WINDOW, 32'h0);
    chk("data", {23'h0, e}, rd);
  endtask : rx_got
  task automatic none;
    apb(1'b0, ARX_OFF_CTRL_STAT_A, 32'h0);
    chk("pending", 32'h0, {31'h0, rd[7]});
  endtask : none
  function automatic int nbits(input logic [2:0] c);
    return c < 3'h4 ? int'(c) + 5 : (c == 3'h7 ? 9 : 8);
  endfunction : nbits
  function automatic logic [8:0] expv(input logic [8:0] v, input int nb);
    return v & ((9'h1 << nb) - 9'h1);
  endfunction : expv
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_frame_done = 1'b0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, ARX_OFF_CTRL_STAT_A, 32'h0);
    chk("stat_a", 32'h0, rd);
    apb(1'b0, ARX_OFF_CTRL_B, 32'h0);
    chk("ctrl_b", 32'h6, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, ARX_OFF_BAUD_DIVIDER, 32'h1);
    tx_frame_done <= 1'b1;
    @(posedge clock);
    tx_frame_done <= 1'b0;
    apb(1'b0, ARX_OFF_CTRL_STAT_A, 32'h0);
    chk("done", 32'h40, rd);
    apb(1'b1, ARX_OFF_CTRL_STAT_A, 32'h41);
    apb(1'b0, ARX_OFF_CTRL_STAT_A, 32'h0);
    chk("w1c", 32'h1, rd);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ARX_OFF_CTRL_STAT_A, 32'(m * 2));
      far.spb = m ? 8 : 16;
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, ARX_OFF_CTRL_B, 32'(c * 2 + 1));
        n = nbits(3'(c));
        repeat (2) begin
          d = 9'($random(seed));
          far.send(d, n, 1'b1, far.spb);
          rx_got(expv(d, n), 1'b0);
        end
      end
      d = 9'($random(seed));
      far.send(d, 9, 1'b1, m ? 7 : 11);
      fork
        far.send(~d, 9, 1'b1, far.spb);
        rx_got(d, 1'b0);
      join
      rx_got(~d, 1'b0);
      // short low pulse must fail the start vote in either rate
      far.hold(1'b0, m ? 3 : 7);
      far.hold(1'b1, far.spb * 2);
      none();
    end
    apb(1'b1, ARX_OFF_CTRL_STAT_A, 32'h0);
    apb(1'b1, ARX_OFF_CTRL_B, 32'h7);
    far.spb = 16;
    far.send(9'h0A5, 8, 1'b0, 16);
    rx_got(9'h0A5, 1'b1);
    far.hold(1'b0, 7);
    far.hold(1'b1, 24);
    none();
    // second frame lands on an unread one: dropped, overrun raised
    far.send(9'h033, 8, 1'b1, 16);
    far.send(9'h044, 8, 1'b1, 16);
    apb(1'b0, ARX_OFF_CTRL_STAT_A, 32'h0);
    chk("overrun", 32'h88, rd);
    apb(1'b0, ARX_OFF_DATA_WINDOW, 32'h0);
    chk("held", 32'h33, rd);
    apb(1'b1, ARX_OFF_CTRL_STAT_A, 32'h1);
    far.send(9'h011, 8, 1'b0, 16);
    none();
    far.send(9'h022, 8, 1'b1, 16);
    rx_got(9'h022, 1'b0);
    apb(1'b1, ARX_OFF_CTRL_B, 32'hF);
    far.send(9'h055, 9, 1'b1, 16);
    none();
    far.send(9'h1A3, 9, 1'b1, 16);
    rx_got(9'h1A3, 1'b0);
    apb(1'b1, ARX_OFF_CTRL_STAT_A, 32'h0);
    far.send(9'h066, 9, 1'b1, 16);
    rx_got(9'h066, 1'b0);
    far.send(9'h0C3, 9, 1'b1, 16);
    apb(1'b1, ARX_OFF_CTRL_B, 32'hE);
    none();
    end_of_test();
  end
endmodule : arx_receiver_test
bind arx_receiver arx_receiver_checker #(.DIV_W(DIV_W), .ADDR_W(ADDR_W)) arx_receiver_checker_inst (
  .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd,
  .tx_frame_done, .char_size_select, .stop_bits_select, .double_rate_select, .baud_divider);
`default_nettype wire
